// [pkg/amss_defines.svh]
// Constants of the asynchronous memory strobe sequencer
`ifndef AMSS_DEFINES_SVH
`define AMSS_DEFINES_SVH

`define AMSS_CLK_PERIOD_NS  10
`define AMSS_SETUP_W        4
`define AMSS_STROBE_W       6
`define AMSS_HOLD_W         3
`define AMSS_ADDR_W         24
`define AMSS_DATA_W         16
`define AMSS_LANES          2
`define AMSS_STALL_W        8
`define AMSS_PHASE_EXTRA    1
`define AMSS_FIXED_PHASES   3
`define AMSS_RELEASE_MAX    4
`define AMSS_SYNC_STAGES    2
`define AMSS_HELPER_W       16
`define AMSS_RST_STROBE_B   1'b1
`define AMSS_RST_DIR_READ   1'b1

`endif

// [pkg/amss_pkg.sv]
// Types of the asynchronous memory strobe sequencer
package amss_pkg;

  typedef enum logic [4:0] {
    AMSS_IDLE   = 5'h01,
    AMSS_SETUP  = 5'h02,
    AMSS_STROBE = 5'h04,
    AMSS_STALL  = 5'h08,
    AMSS_HOLD   = 5'h10
  } amss_state_t;

endpackage : amss_pkg

// [pkg/amss_stall_if.sv]
// Link between the sequencer and its stall synchroniser and counter
`timescale 1ns/100ps
interface amss_stall_if #(parameter int STALL_W = 8);
  logic               stall_sync;
  logic               count_clr;
  logic               count_en;
  logic [STALL_W-1:0] stall_count;

  modport sync_end (input count_clr, input count_en, output stall_sync, output stall_count);
  modport seq_end  (output count_clr, output count_en, input stall_sync, input stall_count);
endinterface : amss_stall_if

// [hdl/amss_stall_sync.sv]
// Stall pin synchroniser and stall cycle counter
`timescale 1ns/100ps
`include "amss_defines.svh"
module amss_stall_sync #(
  parameter int STALL_W = `AMSS_STALL_W
) (
  input  wire logic     clock,
  input  wire logic     rst_b,
  input  wire logic     memory_stall_pin,
  amss_stall_if.sync_end stall_port
);

  logic               meta_r;
  logic               sync_r;
  logic [STALL_W-1:0] count_r;
  logic [STALL_W-1:0] count_nxt;

  // Saturate rather than wrap so a stuck stall pin never reports a short stretch
  always_comb begin
    count_nxt = count_r;
    if (stall_port.count_clr) begin
      count_nxt = '0;
    end else if (stall_port.count_en && (count_r != {STALL_W{1'b1}})) begin
      count_nxt = count_r + STALL_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_r  <= 1'b0;
      sync_r  <= 1'b0;
      count_r <= '0;
    end else begin
      meta_r  <= memory_stall_pin;
      sync_r  <= meta_r;
      count_r <= count_nxt;
    end
  end

  assign stall_port.stall_sync  = sync_r;
  assign stall_port.stall_count = count_r;

  a_sync_two_stage: assert property (
    @(posedge clock) disable iff (!rst_b)
    ##2 (sync_r == $past(memory_stall_pin, 2))
  ) else $error("stall synchroniser latency is not two cycles");

endmodule : amss_stall_sync

// [hdl/amss_sequencer.sv]
// Asynchronous memory strobe sequencer: setup, strobe, stall and hold phases
`timescale 1ns/100ps
`include "amss_defines.svh"
module amss_sequencer import amss_pkg::*; #(
  parameter int SETUP_W  = `AMSS_SETUP_W,
  parameter int STROBE_W = `AMSS_STROBE_W,
  parameter int HOLD_W   = `AMSS_HOLD_W,
  parameter int ADDR_W   = `AMSS_ADDR_W,
  parameter int DATA_W   = `AMSS_DATA_W,
  parameter int LANES    = `AMSS_LANES,
  parameter int STALL_W  = `AMSS_STALL_W
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                req_valid,
  input  wire logic                req_write,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [LANES-1:0]    req_lanes,
  input  wire logic [DATA_W-1:0]   req_wdata,
  output logic                     req_ready,
  output logic [DATA_W-1:0]        rd_data,
  output logic                     rd_valid,
  output logic [STALL_W-1:0]       stall_cycles,
  input  wire logic [SETUP_W-1:0]  read_setup_cycles,
  input  wire logic [STROBE_W-1:0] read_strobe_cycles,
  input  wire logic [HOLD_W-1:0]   read_hold_cycles,
  input  wire logic [SETUP_W-1:0]  write_setup_cycles,
  input  wire logic [STROBE_W-1:0] write_strobe_cycles,
  input  wire logic [HOLD_W-1:0]   write_hold_cycles,
  input  wire logic                extended_stall_mode,
  input  wire logic                select_strobe_mode,
  input  wire logic                memory_stall_pin,
  output logic                     mem_cs_b,
  output logic                     mem_oe_b,
  output logic                     mem_we_b,
  output logic [LANES-1:0]         byte_lane_enables_b,
  output logic                     read_not_write_dir,
  output logic [ADDR_W-1:0]        mem_addr,
  output logic [DATA_W-1:0]        mem_dout,
  output logic                     mem_dout_oe,
  input  wire logic [DATA_W-1:0]   mem_din
);
  localparam int CNT_W = STROBE_W;
  if (STROBE_W < SETUP_W || STROBE_W < HOLD_W || STALL_W < 1 || DATA_W != 8 * LANES) begin : g_chk
    $error("amss_sequencer: unsupported parameter combination");
  end
  ////////////////////////////////////////////////////////////////////////////////
  amss_stall_if #(.STALL_W(STALL_W)) stall_bus ();
  amss_stall_sync #(.STALL_W(STALL_W)) u_stall (
    .clock            (clock),
    .rst_b            (rst_b),
    .memory_stall_pin (memory_stall_pin),
    .stall_port       (stall_bus.sync_end)
  );
  ////////////////////////////////////////////////////////////////////////////////
  amss_state_t        state_r,  state_nxt;
  logic [CNT_W-1:0]   cnt_r,    cnt_nxt;
  logic [SETUP_W-1:0] setup_r,  setup_nxt;
  logic [STROBE_W-1:0] strobe_r, strobe_nxt;
  logic [HOLD_W-1:0]  hold_r,   hold_nxt;
  logic               wr_r,     wr_nxt;
  logic               ew_r,     ew_nxt;
  logic               ss_r,     ss_nxt;
  logic [ADDR_W-1:0]  addr_r,   addr_nxt;
  logic [LANES-1:0]   lanes_r,  lanes_nxt;
  logic [DATA_W-1:0]  wdata_r,  wdata_nxt;
  logic [DATA_W-1:0]  rdata_r,  rdata_nxt;
  logic               rvalid_r, rvalid_nxt;
  logic               ready_r,  ready_nxt;
  logic               cs_b_r,   cs_b_nxt;
  logic               oe_b_r,   oe_b_nxt;
  logic               we_b_r,   we_b_nxt;
  logic               dir_r,    dir_nxt;
  logic               doe_r,    doe_nxt;
  logic               in_strobe;
  // Fields are captured once so software may retune them mid access safely
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    setup_nxt  = setup_r;
    strobe_nxt = strobe_r;
    hold_nxt   = hold_r;
    wr_nxt     = wr_r;
    ew_nxt     = ew_r;
    ss_nxt     = ss_r;
    addr_nxt   = addr_r;
    lanes_nxt  = (state_r == AMSS_HOLD && cnt_r == '0) ? {LANES{1'b1}} : lanes_r;
    wdata_nxt  = wdata_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    case (state_r)
      AMSS_IDLE: begin
        if (req_valid && ready_r) begin
          wr_nxt     = req_write;
          setup_nxt  = req_write ? write_setup_cycles  : read_setup_cycles;
          strobe_nxt = req_write ? write_strobe_cycles : read_strobe_cycles;
          hold_nxt   = req_write ? write_hold_cycles   : read_hold_cycles;
          ew_nxt     = extended_stall_mode;
          ss_nxt     = select_strobe_mode;
          addr_nxt   = req_addr;
          lanes_nxt  = ~req_lanes;
          wdata_nxt  = req_wdata;
          cnt_nxt    = CNT_W'(setup_nxt);
          state_nxt  = AMSS_SETUP;
        end
      end
      AMSS_SETUP: begin
        if (cnt_r == '0) begin
          cnt_nxt   = CNT_W'(strobe_r);
          state_nxt = AMSS_STROBE;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      AMSS_STROBE: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else if (ew_r && stall_bus.stall_sync) begin
          state_nxt = AMSS_STALL;
        end else begin
          cnt_nxt   = CNT_W'(hold_r);
          state_nxt = AMSS_HOLD;
        end
      end
      AMSS_STALL: begin
        if (!stall_bus.stall_sync) begin
          cnt_nxt   = CNT_W'(hold_r);
          state_nxt = AMSS_HOLD;
        end
      end
      AMSS_HOLD: begin
        if (cnt_r == '0) begin
          state_nxt = AMSS_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      default: begin
        state_nxt = AMSS_IDLE;
      end
    endcase
    if (!wr_r && (state_r == AMSS_STROBE || state_r == AMSS_STALL) && state_nxt == AMSS_HOLD) begin
      rdata_nxt  = mem_din;
      rvalid_nxt = 1'b1;
    end
    // Pins follow the next state so every output leaves a flip-flop aligned with state_r
    in_strobe = (state_nxt == AMSS_STROBE) || (state_nxt == AMSS_STALL);
    ready_nxt = (state_nxt == AMSS_IDLE);
    cs_b_nxt  = (state_nxt == AMSS_IDLE);
    oe_b_nxt  = !(in_strobe && !wr_nxt);
    we_b_nxt  = !(in_strobe && wr_nxt);
    dir_nxt   = !(wr_nxt && !cs_b_nxt);
    doe_nxt   = wr_nxt && !cs_b_nxt;
  end
  assign stall_bus.count_clr = (state_r == AMSS_IDLE);
  assign stall_bus.count_en  = (state_r == AMSS_STALL);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= AMSS_IDLE;
      cnt_r    <= '0;
      setup_r  <= '0;
      strobe_r <= '0;
      hold_r   <= '0;
      wr_r     <= 1'b0;
      ew_r     <= 1'b0;
      ss_r     <= 1'b0;
      addr_r   <= '0;
      lanes_r  <= {LANES{1'b1}};
      wdata_r  <= '0;
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
      ready_r  <= 1'b0;
      cs_b_r   <= `AMSS_RST_STROBE_B;
      oe_b_r   <= `AMSS_RST_STROBE_B;
      we_b_r   <= `AMSS_RST_STROBE_B;
      dir_r    <= `AMSS_RST_DIR_READ;
      doe_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      setup_r  <= setup_nxt;
      strobe_r <= strobe_nxt;
      hold_r   <= hold_nxt;
      wr_r     <= wr_nxt;
      ew_r     <= ew_nxt;
      ss_r     <= ss_nxt;
      addr_r   <= addr_nxt;
      lanes_r  <= lanes_nxt;
      wdata_r  <= wdata_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      ready_r  <= ready_nxt;
      cs_b_r   <= cs_b_nxt;
      oe_b_r   <= oe_b_nxt;
      we_b_r   <= we_b_nxt;
      dir_r    <= dir_nxt;
      doe_r    <= doe_nxt;
    end
  end
  assign req_ready           = ready_r;
  assign rd_data             = rdata_r;
  assign rd_valid            = rvalid_r;
  assign stall_cycles        = stall_bus.stall_count;
  assign mem_cs_b            = cs_b_r;
  assign mem_oe_b            = oe_b_r;
  assign mem_we_b            = we_b_r;
  assign byte_lane_enables_b = lanes_r;
  assign read_not_write_dir  = dir_r;
  assign mem_addr            = addr_r;
  assign mem_dout            = wdata_r;
  assign mem_dout_oe         = doe_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Helper counters for the checks below only
  logic [`AMSS_HELPER_W-1:0] cs_len_r,   cs_len_nxt;
  logic [`AMSS_HELPER_W-1:0] str_len_r,  str_len_nxt;
  logic [`AMSS_HELPER_W-1:0] hold_len_r, hold_len_nxt;
  logic                      seen_r,     seen_nxt;
  always_comb begin
    cs_len_nxt   = cs_b_r ? '0 : cs_len_r + `AMSS_HELPER_W'(1);
    str_len_nxt  = (oe_b_r && we_b_r) ? '0 : str_len_r + `AMSS_HELPER_W'(1);
    seen_nxt     = !cs_b_r && (seen_r || !oe_b_r || !we_b_r);
    hold_len_nxt = (!cs_b_r && oe_b_r && we_b_r && seen_r) ? hold_len_r + `AMSS_HELPER_W'(1)
                                                           : '0;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_len_r   <= '0;
      str_len_r  <= '0;
      hold_len_r <= '0;
      seen_r     <= 1'b0;
    end else begin
      cs_len_r   <= cs_len_nxt;
      str_len_r  <= str_len_nxt;
      hold_len_r <= hold_len_nxt;
      seen_r     <= seen_nxt;
    end
  end
  a_read_setup_lead: assert property (
    @(posedge clock) disable iff (!rst_b)
    $fell(oe_b_r) |-> (cs_len_r == `AMSS_HELPER_W'(setup_r) + `AMSS_HELPER_W'(1)) && !wr_r
  ) else $error("read setup from select to output enable is wrong");
  a_write_setup_lead: assert property (
    @(posedge clock) disable iff (!rst_b)
    $fell(we_b_r) |-> (cs_len_r == `AMSS_HELPER_W'(setup_r) + `AMSS_HELPER_W'(1))
                      && !dir_r && doe_r
  ) else $error("write setup from select to write strobe is wrong");
  a_oe_low_len: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(oe_b_r) |-> (str_len_r == `AMSS_HELPER_W'(strobe_r) + `AMSS_HELPER_W'(1)
                       + `AMSS_HELPER_W'(stall_cycles))
  ) else $error("output enable low time is wrong");
  a_we_low_len: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(we_b_r) |-> (str_len_r >= `AMSS_HELPER_W'(strobe_r) + `AMSS_HELPER_W'(1))
  ) else $error("write strobe low time too short");
  a_hold_tail_len: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(cs_b_r) |-> (hold_len_r == `AMSS_HELPER_W'(hold_r) + `AMSS_HELPER_W'(1))
  ) else $error("hold from strobe end to select release is wrong");
  a_access_cycle_len: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(cs_b_r) |-> (cs_len_r == `AMSS_HELPER_W'(setup_r) + `AMSS_HELPER_W'(strobe_r)
                       + `AMSS_HELPER_W'(hold_r) + `AMSS_HELPER_W'(stall_cycles)
                       + `AMSS_HELPER_W'(`AMSS_FIXED_PHASES))
  ) else $error("access cycle length is wrong");
  a_stall_release: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_r == AMSS_STALL && !memory_stall_pin) ##1 !memory_stall_pin
      |-> ##[0:3] (oe_b_r && we_b_r)
  ) else $error("strobe not released within four clocks of stall end");
  a_stall_only_enabled: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_r == AMSS_STALL) |-> ew_r && $past(stall_bus.stall_sync)
  ) else $error("strobe stretched without stall mode or stall");
  a_cfg_held: assert property (
    @(posedge clock) disable iff (!rst_b)
    (!cs_b_r && !$past(cs_b_r)) |-> $stable(setup_r) && $stable(strobe_r) && $stable(hold_r)
      && $stable(ew_r) && $stable(wr_r) && $stable(addr_r) && $stable(ss_r)
  ) else $error("captured configuration changed during an access");
endmodule : amss_sequencer

// [verif/amss_mem_model.sv]
// Behavioural asynchronous memory with a stall pin driven on command
`timescale 1ns/100ps
module amss_mem_model (
  input  wire logic        clock,
  input  wire logic        mem_cs_b,
  input  wire logic        mem_oe_b,
  input  wire logic        mem_we_b,
  input  wire logic [1:0]  byte_lane_enables_b,
  input  wire logic [23:0] mem_addr,
  input  wire logic [15:0] mem_dout,
  input  wire logic [7:0]  stall_len,
  output logic      [15:0] mem_din,
  output logic             memory_stall_pin
);
  logic [15:0] mem_r [0:255];
  logic [15:0] idle_r;
  logic        strobe_d;
  logic [7:0]  cnt_r;
  wire         drv    = !mem_cs_b && !mem_oe_b;
  wire         strobe = !mem_cs_b && !(mem_oe_b && mem_we_b);

  // Released bus starts at the inverted word and toggles every cycle, so a sample one cycle late never sees the old word
  assign mem_din = drv ? mem_r[mem_addr[7:0]] : idle_r;

  initial begin
    idle_r = 16'h5a5a;
    strobe_d = 1'b0;
    cnt_r = 8'h00;
    memory_stall_pin = 1'b0;
    for (int i = 0; i < 256; i++) mem_r[i] = 16'h0000;
  end

  always @(posedge clock) begin
    idle_r <= drv ? ~mem_din : ~idle_r;
    if (!mem_cs_b && !mem_we_b) begin
      if (!byte_lane_enables_b[0]) mem_r[mem_addr[7:0]][7:0] <= mem_dout[7:0];
      if (!byte_lane_enables_b[1]) mem_r[mem_addr[7:0]][15:8] <= mem_dout[15:8];
    end
    strobe_d <= strobe;
    // Raised one cycle into the strobe, held stall_len (at least 2) cycles
    if (strobe && !strobe_d && stall_len >= 8'h02) begin
      memory_stall_pin <= 1'b1;
      cnt_r <= stall_len - 8'h01;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      memory_stall_pin <= 1'b0;
    end
  end
endmodule : amss_mem_model

// [verif/tb_async_memory_strobe_sequencer.sv]
// Self-checking bench for the asynchronous memory strobe sequencer
`timescale 1ns/100ps
module tb_async_memory_strobe_sequencer;
  logic        clock, rst_b, req_valid, req_write, req_ready, rd_valid;
  logic        extended_stall_mode, select_strobe_mode, memory_stall_pin;
  logic        mem_cs_b, mem_oe_b, mem_we_b, read_not_write_dir, mem_dout_oe;
  logic [23:0] req_addr, mem_addr, seen_addr;
  logic [1:0]  req_lanes, byte_lane_enables_b, seen_ln_b;
  logic [15:0] req_wdata, rd_data, mem_dout, mem_din, rdata_seen;
  logic [7:0]  stall_cycles, stall_len, stall_seen;
  logic [3:0]  read_setup_cycles, write_setup_cycles;
  logic [5:0]  read_strobe_cycles, write_strobe_cycles;
  logic [2:0]  read_hold_cycles, write_hold_cycles;
  logic        seen_dir, seen_doe;
  logic [43:0] ref_v;
  int          error_cnt, samples_checked, setup_n, strobe_n, hold_n, total_n, unstable, rv_n;
  int          s_tab [3] = '{0, 3, 15};
  int          st_tab [3] = '{0, 5, 63};
  int          h_tab [3] = '{0, 2, 7};

  amss_sequencer uut (.clock, .rst_b, .req_valid, .req_write, .req_addr, .req_lanes,
    .req_wdata, .req_ready, .rd_data, .rd_valid, .stall_cycles, .read_setup_cycles,
    .read_strobe_cycles, .read_hold_cycles, .write_setup_cycles, .write_strobe_cycles,
    .write_hold_cycles, .extended_stall_mode, .select_strobe_mode, .memory_stall_pin,
    .mem_cs_b, .mem_oe_b, .mem_we_b, .byte_lane_enables_b, .read_not_write_dir, .mem_addr,
    .mem_dout, .mem_dout_oe, .mem_din);

  amss_mem_model mem (.clock, .mem_cs_b, .mem_oe_b, .mem_we_b, .byte_lane_enables_b,
    .mem_addr, .mem_dout, .stall_len, .mem_din, .memory_stall_pin);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic cfg(input int rs, input int rt, input int rh, input int ws, input int wt,
                     input int wh, input logic ew, input logic ss);
    read_setup_cycles <= 4'(rs);
    read_strobe_cycles <= 6'(rt);
    read_hold_cycles <= 3'(rh);
    write_setup_cycles <= 4'(ws);
    write_strobe_cycles <= 6'(wt);
    write_hold_cycles <= 3'(wh);
    extended_stall_mode <= ew;
    select_strobe_mode <= ss;
  endtask : cfg

  // One request, then the whole select-low span is measured cycle by cycle
  task automatic access(input logic wr, input logic [23:0] a, input logic [1:0] ln,
                        input logic [15:0] d);
    int n;
    n = 0;
    {setup_n, strobe_n, hold_n, total_n, unstable, rv_n} = '0;
    req_write <= wr;
    req_addr <= a;
    req_lanes <= ln;
    req_wdata <= d;
    req_valid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    while (n < 600) begin
      @(posedge clock);
      n++;
      if (rd_valid === 1'b1) begin
        rv_n++;
        rdata_seen = rd_data;
      end
      if (mem_cs_b === 1'b0) begin
        total_n++;
        if (mem_oe_b === 1'b0 || mem_we_b === 1'b0) strobe_n++;
        else if (strobe_n == 0) setup_n++;
        else hold_n++;
        if (total_n == 1) begin
          ref_v = {mem_addr, byte_lane_enables_b, read_not_write_dir, mem_dout_oe,
                   wr ? mem_dout : 16'h0000};
          {seen_addr, seen_ln_b, seen_dir, seen_doe} = ref_v[43:16];
        end else if ({mem_addr, byte_lane_enables_b, read_not_write_dir, mem_dout_oe,
                      wr ? mem_dout : 16'h0000} !== ref_v) unstable++;
      end else if (total_n > 0) break;
    end
    if (n >= 600) begin
      error_cnt++;
      give_verdict();
    end
    stall_seen = stall_cycles;
  endtask : access

  task automatic verify(input logic wr, input logic [23:0] a, input logic [1:0] ln,
                        input int s, input int st, input int h, input logic stretch);
    check("setup", 24'(s + 1), 24'(setup_n));
    check("hold", 24'(h + 1), 24'(hold_n));
    check("strobe", 24'(st + 1 + stall_seen), 24'(strobe_n));
    check("cycle", 24'(s + st + h + 3 + stall_seen), 24'(total_n));
    check("stretch", {23'h0, stretch}, {23'h0, stall_seen != 8'h00});
    if (stretch) check("release", 24'h1, {23'h0, strobe_n <= stall_len + 5});
    check("held", 24'h0, 24'(unstable));
    check("addr", a, seen_addr);
    check("lanes", {22'h0, ~ln}, {22'h0, seen_ln_b});
    check("dir", {22'h0, !wr, wr}, {22'h0, seen_dir, seen_doe});
    check("rd_valid", {23'h0, !wr}, 24'(rv_n));
  endtask : verify

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, req_valid, req_write, req_addr, req_lanes, req_wdata, stall_len} = '0;
    {error_cnt, samples_checked} = '0;
    cfg(0, 0, 0, 0, 0, 0, 1'b0, 1'b0);
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check("idle", 24'h3d, {18'h0, mem_cs_b, mem_oe_b, mem_we_b, read_not_write_dir,
                            mem_dout_oe, req_ready});
    @(posedge clock);
    $display("test reset done");
    // Read and write timings differ in the first and last rows so a swapped field shows up
    for (int i = 0; i < 3; i++) begin
      cfg(s_tab[i], st_tab[i], h_tab[i], s_tab[2-i], st_tab[2-i], h_tab[2-i], 1'b0, i[0]);
      access(1'b1, {16'h5a3c, 8'(8'h10 + i)}, 2'b11, 16'(16'h3c00 + i * 16'h0111));
      verify(1'b1, {16'h5a3c, 8'(8'h10 + i)}, 2'b11, s_tab[2-i], st_tab[2-i], h_tab[2-i], 0);
      access(1'b0, {16'h5a3c, 8'(8'h10 + i)}, 2'b11, 16'h0000);
      verify(1'b0, {16'h5a3c, 8'(8'h10 + i)}, 2'b11, s_tab[i], st_tab[i], h_tab[i], 0);
      check("rdata", 24'(16'h3c00 + i * 16'h0111), {8'h0, rdata_seen});
    end
    $display("test phase lengths done");
    access(1'b1, 24'h5a3c10, 2'b01, 16'hffc3);
    // Fields still hold the last table row: shortest write, longest read
    verify(1'b1, 24'h5a3c10, 2'b01, 0, 0, 0, 1'b0);
    access(1'b0, 24'h5a3c10, 2'b10, 16'h0000);
    verify(1'b0, 24'h5a3c10, 2'b10, 15, 63, 7, 1'b0);
    check("lane merge", 24'h003cc3, {8'h0, rdata_seen});
    $display("test byte lanes done");
    // Pin held well past the programmed strobe end: stretched only in stall mode
    stall_len <= 8'd14;
    for (int m = 1; m >= 0; m--) begin
      cfg(2, 7, 1, 1, 7, 2, m[0], 1'b1);
      access(1'b1, 24'h000020, 2'b11, 16'h9e71);
      verify(1'b1, 24'h000020, 2'b11, 1, 7, 2, m[0]);
      // Pin time past the 8 strobe cycles, plus synchroniser and release latency of 3
      check("stall count", 24'(m * (int'(stall_len) - 7 + 3)), {16'h0, stall_seen});
      access(1'b0, 24'h000020, 2'b11, 16'h0000);
      verify(1'b0, 24'h000020, 2'b11, 2, 7, 1, m[0]);
      check("stall count", 24'(m * (int'(stall_len) - 7 + 3)), {16'h0, stall_seen});
      check("stall rdata", 24'h009e71, {8'h0, rdata_seen});
    end
    $display("test stall stretch done");
    give_verdict();
  end
endmodule : tb_async_memory_strobe_sequencer
